//--- zsc_top.sv
`timescale 1ns/1ps
`include "zsc_map.svh"
module zsc_top #(
   parameter int NUM_DI = `ZSC_NUM_DI,
   parameter int NUM_DO = `ZSC_NUM_DO,
   parameter int FW = `ZSC_FUNC_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // motor feedback (drive clock domain)
   input wire logic signed [`ZSC_SPD_W-1:0] motor_speed,
   input wire logic signed [`ZSC_POS_W-1:0] motor_pos,
   input wire logic index_pulse,
   input wire logic speed_ctrl_mode,
   // clamp settings
   input wire zsc_pkg::zsc_clamp_cfg_t clamp_cfg,
   input wire logic [`ZSC_SPD_W-1:0] brake_still_thr,
   // input conditioning settings
   input wire logic [`ZSC_FILT_W-1:0] di_filt_cycles,
   input wire logic [NUM_DI*FW-1:0] di_func,
   input wire logic [3:0] di_inv_mask_lo,
   input wire logic [3:0] di_inv_mask_hi,
   // output conditioning settings
   input wire logic [NUM_DO*FW-1:0] do_func,
   input wire logic [3:0] do_inv_mask,
   input wire logic brake_output,
   // digital pins
   input wire logic [NUM_DI-1:0] di_pin,
   output logic [NUM_DO-1:0] do_pin,
   // status and command
   output logic clamp_request_input,
   output logic servo_on_input,
   output logic clamp_active_state,
   output logic motor_still,
   output zsc_pkg::zsc_cmd_t cmd
);
   import zsc_pkg::*;

   // ---- digital inputs
   logic [NUM_DI-1:0] di_s1_reg;
   logic [NUM_DI-1:0] di_s2_reg;
   logic [NUM_DI-1:0] di_filt;
   logic [NUM_DI-1:0] di_inv;
   logic [NUM_DI-1:0] di_logic;
   wire [NUM_DI-1:0] di_mask = {di_inv_mask_hi[0], di_inv_mask_lo};

   // two-flop synchroniser on the pins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         di_s1_reg <= '0;
         di_s2_reg <= '0;
      end else begin
         di_s1_reg <= di_pin;
         di_s2_reg <= di_s1_reg;
      end
   end

   // per-input filter, inversion, function decode
   logic [NUM_DI-1:0] hit_clamp;
   logic [NUM_DI-1:0] hit_srv;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DI; gi++) begin : g_di
         zsc_di_filter #(.W(`ZSC_FILT_W)) u_filt (
            .clk(clk),
            .arst_n(arst_n),
            .din_sync(di_s2_reg[gi]),
            .filt_cycles(di_filt_cycles),
            .dout(di_filt[gi])
         );
         assign di_inv[gi] = di_filt[gi] ^ di_mask[gi];
         // code 0 matches no function
         assign hit_clamp[gi] = di_inv[gi] && (di_func[gi*FW +: FW] == FW'(`ZSC_DI_FN_CLAMP));
         assign hit_srv[gi] = di_inv[gi] && (di_func[gi*FW +: FW] == FW'(`ZSC_DI_FN_SRV_ON));
      end
   endgenerate
   assign di_logic = di_inv;
   wire clamp_req = |hit_clamp;
   wire srv_req = |hit_srv;

   // ---- speed comparisons
   wire [`ZSC_SPD_W-1:0] spd_abs = motor_speed[`ZSC_SPD_W-1] ?
      `ZSC_SPD_W'(-motor_speed) : `ZSC_SPD_W'(motor_speed);
   wire [`ZSC_SPD_W:0] release_lvl = {1'b0, clamp_cfg.zero_thr} + {1'b0, clamp_cfg.zero_hyst};
   wire below_zero = spd_abs < clamp_cfg.zero_thr;
   wire above_release = {1'b0, spd_abs} > release_lvl;
   wire still_now = spd_abs < brake_still_thr;

   // ---- offset from index: laps * 10000 + pulses, signed
   wire signed [`ZSC_POS_W-1:0] laps_ext = `ZSC_POS_W'(clamp_cfg.offset_laps);
   wire signed [`ZSC_POS_W-1:0] puls_ext = `ZSC_POS_W'(clamp_cfg.offset_pulses);
   wire signed [`ZSC_POS_W-1:0] offset_pulses =
      `ZSC_POS_W'(laps_ext * $signed(`ZSC_PULSES_PER_LAP)) + puls_ext;
   // positive counts toward CCW (increasing position)
   logic signed [`ZSC_POS_W-1:0] index_pos_reg;
   wire signed [`ZSC_POS_W-1:0] index_target = `ZSC_POS_W'(index_pos_reg + offset_pulses);

   // latch position at each index pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         index_pos_reg <= `ZSC_RST_POS;
      end else if (index_pulse) begin
         index_pos_reg <= motor_pos;
      end
   end

   // ---- clamp state machine
   zsc_state_t state_reg;
   zsc_state_t state_next;
   logic [`ZSC_POS_W-1:0] hold_pos_reg;
   logic [`ZSC_POS_W-1:0] hold_pos_next;
   wire clamp_enter = speed_ctrl_mode && clamp_req && below_zero;
   wire clamp_leave = above_release || !clamp_req || !speed_ctrl_mode;

   always_comb begin
      state_next = state_reg;
      hold_pos_next = hold_pos_reg;
      case (state_reg)
         ZSC_ST_FREE: begin
            if (clamp_enter) begin
               case (clamp_cfg.mode)
                  `ZSC_MODE_FORCE_ZERO: begin
                     state_next = ZSC_ST_ZERO;
                  end
                  `ZSC_MODE_HOLD_STOP: begin
                     state_next = ZSC_ST_HOLD;
                     hold_pos_next = motor_pos;
                  end
                  `ZSC_MODE_HOLD_INDEX: begin
                     state_next = ZSC_ST_HOLD;
                     hold_pos_next = index_target;
                  end
                  default: begin
                     state_next = ZSC_ST_ZERO;
                  end
               endcase
            end
         end
         ZSC_ST_ZERO, ZSC_ST_HOLD: begin
            if (clamp_leave) begin
               state_next = ZSC_ST_FREE;
            end
         end
         default: begin
            state_next = ZSC_ST_FREE;
         end
      endcase
   end

   // state and held position
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ZSC_ST_FREE;
         hold_pos_reg <= `ZSC_RST_POS;
      end else begin
         state_reg <= state_next;
         hold_pos_reg <= hold_pos_next;
      end
   end

   // ---- registered status and command outputs
   logic still_reg;
   zsc_cmd_t cmd_reg;
   wire in_hold = state_reg == ZSC_ST_HOLD;
   wire in_zero = state_reg == ZSC_ST_ZERO;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         still_reg <= 1'b0;
         cmd_reg <= '0;
      end else begin
         still_reg <= still_now;
         cmd_reg.speed_mode <= speed_ctrl_mode && !in_hold;
         cmd_reg.zero_speed_cmd <= in_zero;
         cmd_reg.pos_mode <= in_hold;
         cmd_reg.pos_target <= hold_pos_reg;
      end
   end

   // ---- digital outputs: select, then invert
   logic [NUM_DO-1:0] do_sel;
   logic [NUM_DO-1:0] do_reg;
   wire [NUM_DO-1:0] do_mask = do_inv_mask[NUM_DO-1:0]; // bit3 reserved
   genvar go;
   generate
      for (go = 0; go < NUM_DO; go++) begin : g_do
         wire [FW-1:0] fn = do_func[go*FW +: FW];
         assign do_sel[go] = (fn == FW'(`ZSC_DO_FN_CLAMP)) ? (state_reg != ZSC_ST_FREE) :
                             (fn == FW'(`ZSC_DO_FN_BRAKE)) ? brake_output :
                             (fn == FW'(`ZSC_DO_FN_STILL)) ? still_reg :
                             1'b0;
      end
   endgenerate

   // output flops after inversion
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         do_reg <= '0;
      end else begin
         do_reg <= do_sel ^ do_mask;
      end
   end

   assign do_pin = do_reg;
   assign clamp_request_input = clamp_req;
   assign servo_on_input = srv_req;
   assign clamp_active_state = state_reg != ZSC_ST_FREE;
   assign motor_still = still_reg;
   assign cmd = cmd_reg;
   wire unused_ok = ^di_logic;
endmodule

//--- zsc_map.svh
`ifndef ZSC_MAP_SVH
`define ZSC_MAP_SVH
// widths and counts
`define ZSC_SPD_W 16
`define ZSC_POS_W 32
`define ZSC_NUM_DI 5
`define ZSC_NUM_DO 3
`define ZSC_FUNC_W 6
`define ZSC_FILT_W 16
// offset scaling: pulses per lap
`define ZSC_PULSES_PER_LAP 32'h0000_2710
// clamp mode encodings
`define ZSC_MODE_FORCE_ZERO 2'h0
`define ZSC_MODE_HOLD_STOP 2'h1
`define ZSC_MODE_HOLD_INDEX 2'h2
// input function codes
`define ZSC_DI_FN_NONE 6'h00
`define ZSC_DI_FN_CLAMP 6'h01
`define ZSC_DI_FN_SRV_ON 6'h02
// output function codes
`define ZSC_DO_FN_NONE 6'h00
`define ZSC_DO_FN_CLAMP 6'h01
`define ZSC_DO_FN_BRAKE 6'h02
`define ZSC_DO_FN_STILL 6'h03
// reset values
`define ZSC_RST_POS 32'h0000_0000
`define ZSC_RST_FILT 16'h0000
`endif

//--- zsc_pkg.sv
`include "zsc_map.svh"
package zsc_pkg;
   typedef enum logic [1:0] {
      ZSC_ST_FREE = 2'b00,
      ZSC_ST_ZERO = 2'b01,
      ZSC_ST_HOLD = 2'b10
   } zsc_state_t;

   // clamp settings group
   typedef struct packed {
      logic [`ZSC_SPD_W-1:0] zero_thr;
      logic [`ZSC_SPD_W-1:0] zero_hyst;
      logic [1:0] mode;
      logic signed [15:0] offset_laps;
      logic signed [15:0] offset_pulses;
   } zsc_clamp_cfg_t;

   // command output group
   typedef struct packed {
      logic speed_mode;
      logic zero_speed_cmd;
      logic pos_mode;
      logic [`ZSC_POS_W-1:0] pos_target;
   } zsc_cmd_t;
endpackage

//--- zsc_di_filter.sv
`timescale 1ns/1ps
`include "zsc_map.svh"
// debounce: output follows input once it has differed for filt_cycles+1 cycles
module zsc_di_filter #(
   parameter int W = `ZSC_FILT_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // data
   input wire logic din_sync,
   input wire logic [W-1:0] filt_cycles,
   output logic dout
);
   import zsc_pkg::*;
   logic [W-1:0] cnt_reg;
   logic dout_reg;
   wire differs = din_sync != dout_reg;
   wire expired = cnt_reg >= filt_cycles;

   // count stable cycles of a differing level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
         dout_reg <= 1'b0;
      end else if (!differs) begin
         cnt_reg <= '0;
      end else if (expired) begin
         dout_reg <= din_sync;
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end
   assign dout = dout_reg;
endmodule

//--- zsc_top_checker.sv
`timescale 1ns/1ps
module zsc_top_checker #(
   parameter int NUM_DO = 3,
   parameter int FW = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched ports
   input wire logic signed [15:0] motor_speed,
   input wire logic speed_ctrl_mode,
   input wire zsc_pkg::zsc_clamp_cfg_t clamp_cfg,
   input wire logic [15:0] brake_still_thr,
   input wire logic [NUM_DO*FW-1:0] do_func,
   input wire logic [3:0] do_inv_mask,
   input wire logic brake_output,
   input wire logic [NUM_DO-1:0] do_pin,
   input wire logic clamp_request_input,
   input wire logic clamp_active_state,
   input wire logic motor_still,
   input wire zsc_pkg::zsc_cmd_t cmd
);
   import zsc_pkg::*;
   logic [15:0] mag;
   logic [16:0] lim;
   // speed magnitude and release level
   assign mag = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
   assign lim = clamp_cfg.zero_thr + 17'(clamp_cfg.zero_hyst);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // all three clamp conditions at once
   sequence s_enter;
      speed_ctrl_mode && clamp_request_input && mag < clamp_cfg.zero_thr;
   endsequence
   chk_enter_now: assert property (s_enter |=> clamp_active_state)
      else $error("clamp not engaged");
   chk_enter_cause: assert property ($rose(clamp_active_state) |->
      $past(speed_ctrl_mode && clamp_request_input && mag < clamp_cfg.zero_thr))
      else $error("clamp engaged without cause");
   chk_hold_hyst: assert property (clamp_active_state && speed_ctrl_mode && clamp_request_input && mag <= lim
      |=> clamp_active_state)
      else $error("clamp dropped inside hysteresis");
   chk_release_cause: assert property ($fell(clamp_active_state) |->
      $past(mag > lim || !clamp_request_input || !speed_ctrl_mode))
      else $error("clamp released without cause");
   chk_zero_cmd: assert property (s_enter ##0 !clamp_active_state ##1
      (clamp_cfg.mode inside {2'h0, 2'h3} && $stable(clamp_cfg.mode))
      |=> cmd.zero_speed_cmd && !cmd.pos_mode)
      else $error("zero speed command missing");
   chk_hold_pos: assert property (s_enter ##0 !clamp_active_state ##1
      (clamp_cfg.mode inside {2'h1, 2'h2} && $stable(clamp_cfg.mode))
      |=> cmd.pos_mode && !cmd.speed_mode)
      else $error("position hold missing");
   chk_still_cmp: assert property (1'b1 |=> motor_still == $past(mag < brake_still_thr))
      else $error("standstill flag wrong");
   chk_do_clamp: assert property (do_func[FW-1:0] == 6'h01
      |=> do_pin[0] == $past(clamp_active_state ^ do_inv_mask[0]))
      else $error("output one wrong");
   chk_do_none: assert property (do_func[2*FW-1:FW] == 6'h00 |=> do_pin[1] == $past(do_inv_mask[1]))
      else $error("output two wrong");
   chk_do_brake: assert property (do_func[3*FW-1:2*FW] == 6'h02
      |=> do_pin[2] == $past(brake_output ^ do_inv_mask[2]))
      else $error("output three wrong");
endmodule
bind zsc_top zsc_top_checker #(.NUM_DO(NUM_DO), .FW(FW)) zsc_top_checker_i (.*);

//--- zsc_host_model.sv
`timescale 1ns/1ps
module zsc_host_model (
   // requested levels
   input wire logic [4:0] lvl,
   // driven pins
   output logic [4:0] di_pin
);
   // controller holds its pins at the requested levels
   assign di_pin = lvl;
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   import zsc_pkg::*;
   logic clk, arst_n, index_pulse, speed_ctrl_mode, brake_output;
   logic clamp_request_input, servo_on_input, clamp_active_state, motor_still;
   logic signed [15:0] motor_speed;
   logic signed [31:0] motor_pos;
   logic [15:0] brake_still_thr, di_filt_cycles;
   logic [29:0] di_func;
   logic [17:0] do_func;
   logic [3:0] di_inv_mask_lo, di_inv_mask_hi, do_inv_mask;
   logic [4:0] di_pin, lvl;
   logic [2:0] do_pin;
   logic [31:0] tgt;
   zsc_clamp_cfg_t clamp_cfg;
   zsc_cmd_t cmd;
   int err_total, n_tests, cyc;
   logic signed [15:0] sp[6] = '{16'sh000f, 16'shfff1, 16'sh0010, 16'sh000c, 16'sh000a, 16'sh0009};
   logic signed [15:0] la[3] = '{16'sh0000, 16'sh0002, 16'shffff};
   logic signed [15:0] pu[3] = '{16'sh0000, 16'shfffb, 16'sh0003};
   logic [5:0] ex = 6'h23;
   logic [5:0] st = 6'h3b;
   zsc_top zsc_top_i (.*);
   zsc_host_model zsc_host_model_i (.*);
   // clock
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         results();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // set pin levels, wait out sync and filter
   task pins(input logic [4:0] v);
      lvl = v;
      wt(10);
   endtask
   task results;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      {arst_n, index_pulse, speed_ctrl_mode, brake_output, lvl} = '0;
      {motor_speed, motor_pos, di_inv_mask_lo, di_inv_mask_hi} = '0;
      clamp_cfg = {16'h000a, 16'h0005, 2'h0, 32'h0000_0000};
      brake_still_thr = 16'h0014;
      di_filt_cycles = 16'h0002;
      di_func = {18'h0_0000, 6'h02, 6'h01};
      do_func = {6'h02, 6'h03, 6'h01};
      do_inv_mask = 4'ha;
      wt(4);
      chk("reset", 0, 32'(|{cmd, do_pin, clamp_active_state, motor_still}));
      arst_n = 1;
      // input mapping, inversion after the filter, glitch rejection
      pins(5'h03);
      chk("req", 1, clamp_request_input);
      chk("srv", 1, servo_on_input);
      di_inv_mask_lo = 4'h1;
      wt(1);
      chk("inv", 0, clamp_request_input);
      di_inv_mask_lo = 4'h0;
      lvl = 5'h02;
      wt(2);
      lvl = 5'h03;
      for (int i = 0; i < 8; i++) begin
         wt(1);
         chk("glitch", 1, clamp_request_input);
      end
      // fifth input: only bit0 of its mask counts
      di_func = {6'h01, 24'h00_0000};
      pins(5'h01);
      di_inv_mask_hi = 4'he;
      wt(1);
      chk("di5", 0, clamp_request_input);
      di_inv_mask_hi = 4'h1;
      wt(1);
      chk("di5", 1, clamp_request_input);
      di_inv_mask_hi = 4'h0;
      di_func = {18'h0_0000, 6'h02, 6'h01};
      wt(1);
      chk("srv", 0, servo_on_input);
      // mode 0 clamp and hysteresis walk
      motor_speed = 16'sh0005;
      wt(3);
      chk("cas", 0, clamp_active_state);
      speed_ctrl_mode = 1;
      wt(3);
      chk("cas", 1, clamp_active_state);
      chk("zero", 1, cmd.zero_speed_cmd);
      chk("do1", 1, do_pin[0]);
      for (int i = 0; i < 6; i++) begin
         motor_speed = sp[i];
         wt(3);
         chk("hyst", ex[i], clamp_active_state);
      end
      // position holds: stop point, then index plus offset
      for (int k = 0; k < 3; k++) begin
         pins(5'h00);
         clamp_cfg.mode = (k == 0) ? 2'h1 : 2'h2;
         clamp_cfg.offset_laps = la[k];
         clamp_cfg.offset_pulses = pu[k];
         motor_pos = 32'sh0000_0064;
         index_pulse = 1;
         wt(1);
         index_pulse = 0;
         motor_pos = 32'sh0001_2345;
         pins(5'h01);
         motor_pos = 32'sh0000_0007;
         wt(3);
         tgt = (k == 0) ? 32'h0001_2345 : 32'(100 + la[k] * 10000 + pu[k]);
         chk("pmode", 1, cmd.pos_mode);
         chk("tgt", tgt, cmd.pos_target);
      end
      // unused mode code behaves as forced zero
      pins(5'h00);
      clamp_cfg.mode = 2'h3;
      pins(5'h01);
      chk("m3zero", 1, cmd.zero_speed_cmd);
      chk("m3pos", 0, cmd.pos_mode);
      // standstill and output selection
      speed_ctrl_mode = 0;
      brake_output = 1;
      brake_still_thr = 16'h0010;
      pins(5'h00);
      for (int i = 0; i < 6; i++) begin
         motor_speed = sp[i];
         wt(3);
         chk("still", st[i], motor_still);
         chk("dout", {1'b1, ~st[i], 1'b0}, do_pin);
      end
      do_func = {6'h02, 6'h00, 6'h01};
      wt(3);
      chk("none", 3'h6, do_pin);
      do_inv_mask = 4'h8;
      wt(3);
      chk("rsvd", 3'h4, do_pin);
      results();
   end
endmodule
